// >>> bench/rmis_pin_model.sv
// rmis_pin_model: levels on the remappable pins.
// assumes the bench sets drive_i; the block wins where it drives.
`timescale 1ns/1ps
`default_nettype none
module rmis_pin_model
(
  input  wire logic [25:0] drive_i,
  input  wire logic [25:0] pin_o_i,
  input  wire logic [25:0] oe_i,
  output logic      [25:0] level_o
);
  // a driven pin loops back its own level, so it cannot mimic an input
  assign level_o = (oe_i & pin_o_i) | (~oe_i & drive_i);
endmodule // rmis_pin_model
`default_nettype wire

// >>> bench/rmis_top_properties.sv
// rmis_top_properties: port-level checks of rmis_top.
// assumes bind to rmis_top; shadows registers from observed writes.
`timescale 1ns/1ps
`default_nettype none
module rmis_top_properties
  import rmis_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic [25:0] remappable_pin_n_i,
  input wire logic [25:0] remappable_pin_n_oe_o,
  input wire logic        uart_clear_to_send_in_o,
  input wire logic        uart_receive_in_o,
  input wire logic        map_locked_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic        take;
  logic [15:0] usel, next_usel;
  logic [25:0] dir, next_dir;
  assign take = cyc_i && stb_i && !ack_o && we_i;
  always_comb
  begin
    next_usel = usel;
    next_dir  = dir;
    if (take && adr_i[7:2] == 6'h0 && !map_locked_o)
    begin
      if (sel_i[0]) next_usel[4:0] = dat_i[4:0];
      if (sel_i[1]) next_usel[12:8] = dat_i[12:8];
    end
    if (take && adr_i[7:2] == 6'h1)
      for (int b = 0; b < 26; b++) if (sel_i[b / 8]) next_dir[b] = dat_i[b];
  end
  always_ff @(posedge clk_i)
    if (rst_i)
    begin
      usel <= RMIS_UART_IN_RST;
      dir  <= RMIS_DIR_RST;
    end
    else
    begin
      usel <= next_usel;
      dir  <= next_dir;
    end
  function automatic logic route(logic [4:0] s, logic [25:0] p, logic [25:0] d);
    return (s <= RMIS_SEL_MAX) ? (p[s] & d[s]) : 1'b0;
  endfunction
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_lock_wr;
    s_req ##0 (we_i && adr_i[7:2] == 6'h3);
  endsequence
  ack_answer_a: assert property (s_req |=> ack_o) else $error("no ack after request");
  ack_single_a: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
  ack_cause_a: assert property (!(cyc_i && stb_i && !ack_o) |=> !ack_o) else $error("ack without request");
  dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0) else $error("read data outside ack");
  sel_read_a: assert property (s_req ##0 (!we_i && adr_i[7:2] == 6'h0) |=> dat_o == {16'h0, $past(usel)})
    else $error("selector readback wrong");
  rx_route_a: assert property (uart_receive_in_o == route($past(usel[4:0]), $past(remappable_pin_n_i), $past(dir)))
    else $error("receive input routed wrong");
  cts_route_a: assert property (uart_clear_to_send_in_o == route($past(usel[12:8]), $past(remappable_pin_n_i), $past(dir)))
    else $error("clear to send routed wrong");
  oe_dir_a: assert property (remappable_pin_n_oe_o == ~$past(dir))
    else $error("output enable not inverse of direction");
  lock_set_a: assert property (s_lock_wr ##0 (sel_i[0] && dat_i[0]) |=> map_locked_o)
    else $error("lock write did not lock");
  lock_hold_a: assert property (map_locked_o && !(take && adr_i[7:2] == 6'h3) |=> map_locked_o)
    else $error("lock dropped without lock write");
endmodule // rmis_top_properties
`default_nettype wire
bind rmis_top rmis_top_properties rmis_top_properties_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .remappable_pin_n_i(remappable_pin_n_i), .remappable_pin_n_oe_o(remappable_pin_n_oe_o),
  .uart_clear_to_send_in_o(uart_clear_to_send_in_o), .uart_receive_in_o(uart_receive_in_o),
  .map_locked_o(map_locked_o));

// >>> bench/rmis_top_test.sv
// rmis_top_test: register-driven tests of rmis_top.
// assumes rmis_pin_model for the pins; one clock at 250 MHz.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; $display("FAIL %0t mismatch %h %h", $time, g, e); end end
module rmis_top_test;
  import rmis_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, tx = 1'b0;
  logic [7:0]  adr = 8'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0, q, dat_o;
  logic [25:0] drv = 26'h0, pins, pin_o, oe;
  logic        ack_o, cts_o, rx_o, locked;
  logic [4:0]  codes [3] = '{5'h1a, 5'h1e, 5'h1f};
  int          n_errors = 0, checks = 0;
  always #2 clk_i = ~clk_i;
  rmis_top rmis_top_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .remappable_pin_n_i(pins),
    .remappable_pin_n_o(pin_o), .remappable_pin_n_oe_o(oe), .uart_transmit_out_i(tx),
    .uart_clear_to_send_in_o(cts_o), .uart_receive_in_o(rx_o), .map_locked_o(locked));
  rmis_pin_model rmis_pin_model_inst (.drive_i(drv), .pin_o_i(pin_o), .oe_i(oe), .level_o(pins));
  // ----
  // bus tasks
  // ----
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    i = 0;
    do
    begin
      @(posedge clk_i);
      i++;
    end
    while (ack_o !== 1'b1 && i < 16);
    if (ack_o !== 1'b1)
    begin
      n_errors++;
      $display("FAIL %0t no bus answer", $time);
      stop_test();
    end
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask
  // level-driven pins need one edge to reach the peripheral side
  task automatic pin_chk(input logic [25:0] p, input logic rx_e, input logic cts_e);
    drv <= p;
    repeat (3) @(posedge clk_i);
    `CHK(rx_o, rx_e)
    `CHK(cts_o, cts_e)
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    $display("FAIL %0t watchdog expired", $time);
    stop_test();
  end
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK(oe, 26'h0)
    rd_chk(RMIS_OFS_UART_IN, 32'h00001f1f);
    rd_chk(RMIS_OFS_DIR, 32'h03ffffff);
    rd_chk(8'h20, 32'h0);
    rd_chk(RMIS_OFS_OUT_MAP, 32'h0000001f);
    rd_chk(RMIS_OFS_KEY, 32'h0);
    pin_chk(26'h3ffffff, 1'b0, 1'b0);
    wr(RMIS_OFS_UART_IN, 32'hffffffff);
    rd_chk(RMIS_OFS_UART_IN, 32'h00001f1f);
    for (int n = 0; n < 26; n++)
    begin
      wr(RMIS_OFS_UART_IN, {19'h0, 5'(25 - n), 3'h0, 5'(n)});
      pin_chk(26'h1 << n, 1'b1, 1'b0);
      pin_chk(~(26'h1 << n), 1'b0, 1'b1);
    end
    for (int k = 0; k < 3; k++)
    begin
      wr(RMIS_OFS_UART_IN, {19'h0, codes[k], 3'h0, codes[k]});
      pin_chk(26'h3ffffff, 1'b0, 1'b0);
    end
    wr(RMIS_OFS_UART_IN, 32'h00000305);
    wr(RMIS_OFS_DIR, 32'h03ffffdf);
    pin_chk(26'h3ffffff, 1'b0, 1'b1);
    `CHK(oe, 26'h0000020)
    wr(RMIS_OFS_OUT_MAP, 32'h5);
    rd_chk(RMIS_OFS_OUT_MAP, 32'h00000005);
    tx <= 1'b1;
    pin_chk(26'h0, 1'b0, 1'b0);
    `CHK(pin_o, 26'h0000020)
    rd_chk(RMIS_OFS_UART_IN, 32'h00000305);
    wr(RMIS_OFS_DIR, 32'h03ffffff);
    wr(RMIS_OFS_LOCK, 32'h1);
    `CHK(locked, 1'b1)
    wr(RMIS_OFS_UART_IN, 32'h00000101);
    rd_chk(RMIS_OFS_UART_IN, 32'h00000305);
    pin_chk(26'h0000020, 1'b1, 1'b0);
    rd_chk(RMIS_OFS_PINS, 32'h00000020);
    wr(RMIS_OFS_OUT_MAP, 32'h2);
    rd_chk(RMIS_OFS_OUT_MAP, 32'h00000005);
    // an intervening write must disarm the key sequence
    wr(RMIS_OFS_KEY, {24'h0, RMIS_KEY_FIRST});
    wr(RMIS_OFS_DIR, 32'h03ffffff);
    wr(RMIS_OFS_KEY, {24'h0, RMIS_KEY_SECOND});
    wr(RMIS_OFS_LOCK, 32'h0);
    `CHK(locked, 1'b1)
    rd_chk(RMIS_OFS_LOCK, 32'h00000001);
    wr(RMIS_OFS_KEY, {24'h0, RMIS_KEY_FIRST});
    wr(RMIS_OFS_KEY, {24'h0, RMIS_KEY_SECOND});
    rd_chk(RMIS_OFS_LOCK, 32'h00000003);
    wr(RMIS_OFS_LOCK, 32'h0);
    `CHK(locked, 1'b0)
    wr(RMIS_OFS_UART_IN, 32'h00000101);
    rd_chk(RMIS_OFS_UART_IN, 32'h00000101);
    // reset must also drop a lock taken by software
    wr(RMIS_OFS_LOCK, 32'h1);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK(locked, 1'b0)
    `CHK(pin_o, 26'h0)
    `CHK(oe, 26'h0)
    rd_chk(RMIS_OFS_UART_IN, 32'h00001f1f);
    rd_chk(RMIS_OFS_DIR, 32'h03ffffff);
    stop_test();
  end
endmodule // rmis_top_test
`default_nettype wire

// >>> verilog/rmis_input_mux.sv
// rmis_input_mux: picks one remappable pin for one peripheral input.
// assumes pins are synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module rmis_input_mux
  import rmis_pkg::*;
(
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  rmis_sel_if.mux    path
);
  logic routed;
  logic next_routed;

  // ----------------------------------------
  // selection
  // ----------------------------------------
  always_comb
  begin
    next_routed = 1'b0;
    // codes past the last pin ground the input too
    if (path.sel <= RMIS_SEL_MAX)
    begin
      // pin set as output gives nothing to the peripheral
      next_routed = path.pins[path.sel] & path.dir[path.sel];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      routed <= 1'b0;
    else
      routed <= next_routed;
  end

  assign path.routed = routed;
endmodule // rmis_input_mux
`default_nettype wire

// >>> verilog/rmis_pkg.sv
// rmis_pkg: constants for the remappable input select block.
// assumes a 32-bit classic wishbone slave, byte addresses.
package rmis_pkg;
  // ----------------------------------------
  // pins and selector encoding
  // ----------------------------------------
  localparam int          RMIS_NUM_PINS  = 26;
  localparam int          RMIS_SEL_W     = 5;
  localparam logic [4:0]  RMIS_SEL_GND   = 5'h1f;
  localparam logic [4:0]  RMIS_SEL_MAX   = 5'h19;
  // ----------------------------------------
  // register map (byte offsets)
  // ----------------------------------------
  localparam logic [7:0]  RMIS_OFS_UART_IN  = 8'h00;
  localparam logic [7:0]  RMIS_OFS_DIR      = 8'h04;
  localparam logic [7:0]  RMIS_OFS_OUT_MAP  = 8'h08;
  localparam logic [7:0]  RMIS_OFS_LOCK     = 8'h0c;
  localparam logic [7:0]  RMIS_OFS_KEY      = 8'h10;
  localparam logic [7:0]  RMIS_OFS_PINS     = 8'h14;
  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int          RMIS_RX_LSB    = 0;
  localparam int          RMIS_CTS_LSB   = 8;
  localparam logic [15:0] RMIS_UART_IN_RST = 16'h1f1f;
  localparam logic [25:0] RMIS_DIR_RST   = 26'h3ffffff;
  localparam logic [4:0]  RMIS_OUT_MAP_RST = 5'h1f;
  localparam logic        RMIS_LOCK_RST  = 1'b0;
  // unlock keys, values arbitrary
  localparam logic [7:0]  RMIS_KEY_FIRST  = 8'h46;
  localparam logic [7:0]  RMIS_KEY_SECOND = 8'h57;
  // ----------------------------------------
  // unlock sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    RMIS_KEY_IDLE  = 3'b001,
    RMIS_KEY_HALF  = 3'b010,
    RMIS_KEY_ARMED = 3'b100
  } rmis_key_state_t;
endpackage : rmis_pkg

// >>> verilog/rmis_sel_if.sv
// rmis_sel_if: one selector path between the register file and a mux.
// assumes both ends share clk_i.
`timescale 1ns/1ps
`default_nettype none
interface rmis_sel_if;
  logic [25:0] pins;
  logic [25:0] dir;
  logic [4:0]  sel;
  logic        routed;
  modport mux  (input pins, input dir, input sel, output routed);
  modport regs (output pins, output dir, output sel, input routed);
endinterface : rmis_sel_if
`default_nettype wire

// >>> verilog/rmis_top.sv
// rmis_top: remappable input select with wishbone register access.
// assumes classic wishbone master on clk_i, synchronous active-high reset.
// pin levels must already be synchronous to clk_i; no metastability guard here.
//
// Operation
// - Up to 26 remappable pins take part in remapping.
// - Input mapping and output mapping use separate independent registers.
// - Each peripheral input has a 5-bit selector; value n picks pin n.
// - Only selector values matching existing pins route a pin.
// - Hardware lock blocks spurious mapping changes once established.
// - Mapping changes by register writes at run time.
// - Direction bit one means input; all pins inputs after reset.
//
// The register addresses and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rmis_top
  import rmis_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone classic slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output var  logic [31:0] dat_o,
  output var  logic        ack_o,
  // remappable pins
  input  wire logic [25:0] remappable_pin_n_i,
  output var  logic [25:0] remappable_pin_n_o,
  output var  logic [25:0] remappable_pin_n_oe_o,
  // peripheral side
  input  wire logic        uart_transmit_out_i,
  output logic             uart_clear_to_send_in_o,
  output logic             uart_receive_in_o,
  output var  logic        map_locked_o
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [4:0]      cts_input_selector;
  logic [4:0]      rx_input_selector;
  logic [25:0]     port_direction_register;
  logic [4:0]      tx_output_selector;
  logic            map_locked;
  rmis_key_state_t key_state;
  logic [31:0]     rd_data;
  logic            ack;

  logic [4:0]      next_cts_input_selector;
  logic [4:0]      next_rx_input_selector;
  logic [25:0]     next_port_direction_register;
  logic [4:0]      next_tx_output_selector;
  logic            next_map_locked;
  rmis_key_state_t next_key_state;
  logic [31:0]     next_rd_data;
  logic            next_ack;

  logic [25:0]     next_pin_out;
  logic [25:0]     next_pin_oe;
  logic [25:0]     pin_out;
  logic [25:0]     pin_oe;

  logic            req;
  logic            wr;
  logic            rd;
  logic [7:0]      ofs;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  // answer one cycle after the request; ack drops the next cycle
  assign req = cyc_i & stb_i & ~ack;
  assign wr  = req & we_i;
  assign rd  = req & ~we_i;
  assign ofs = {adr_i[7:2], 2'b00};

  // ----------------------------------------
  // register file and unlock sequencer
  // ----------------------------------------
  always_comb
  begin
    next_cts_input_selector      = cts_input_selector;
    next_rx_input_selector       = rx_input_selector;
    next_port_direction_register = port_direction_register;
    next_tx_output_selector      = tx_output_selector;
    next_map_locked              = map_locked;
    next_key_state               = key_state;

    if (wr)
    begin
      // any write other than the expected key or the first key breaks the sequence
      next_key_state = RMIS_KEY_IDLE;
      case (ofs)
        RMIS_OFS_UART_IN:
        begin
          // locked map ignores writes so stray code cannot reroute
          if (!map_locked)
          begin
            if (sel_i[0])
              next_rx_input_selector = dat_i[RMIS_RX_LSB +: RMIS_SEL_W];
            if (sel_i[1])
              next_cts_input_selector = dat_i[RMIS_CTS_LSB +: RMIS_SEL_W];
          end
        end
        RMIS_OFS_DIR:
        begin
          if (sel_i[0])
            next_port_direction_register[7:0] = dat_i[7:0];
          if (sel_i[1])
            next_port_direction_register[15:8] = dat_i[15:8];
          if (sel_i[2])
            next_port_direction_register[23:16] = dat_i[23:16];
          if (sel_i[3])
            next_port_direction_register[25:24] = dat_i[25:24];
        end
        RMIS_OFS_OUT_MAP:
        begin
          if (!map_locked && sel_i[0])
            next_tx_output_selector = dat_i[4:0];
        end
        RMIS_OFS_LOCK:
        begin
          // locking needs no key; only the way back out is guarded
          if (sel_i[0])
          begin
            if (dat_i[0])
              next_map_locked = 1'b1;
            else if (key_state == RMIS_KEY_ARMED)
              next_map_locked = 1'b0;
          end
        end
        RMIS_OFS_KEY:
        begin
          if (sel_i[0])
          begin
            case (key_state)
              RMIS_KEY_IDLE:
              begin
                if (dat_i[7:0] == RMIS_KEY_FIRST)
                  next_key_state = RMIS_KEY_HALF;
              end
              RMIS_KEY_HALF:
              begin
                if (dat_i[7:0] == RMIS_KEY_SECOND)
                  next_key_state = RMIS_KEY_ARMED;
                else if (dat_i[7:0] == RMIS_KEY_FIRST)
                  next_key_state = RMIS_KEY_HALF;
              end
              RMIS_KEY_ARMED:
              begin
                if (dat_i[7:0] == RMIS_KEY_FIRST)
                  next_key_state = RMIS_KEY_HALF;
              end
              default:
              begin
                next_key_state = RMIS_KEY_IDLE;
              end
            endcase
          end
        end
        default:
        begin
          // unmapped: acknowledged, nothing stored
          next_key_state = RMIS_KEY_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cts_input_selector      <= RMIS_SEL_GND;
      rx_input_selector       <= RMIS_SEL_GND;
      port_direction_register <= RMIS_DIR_RST;
      tx_output_selector      <= RMIS_OUT_MAP_RST;
      map_locked              <= RMIS_LOCK_RST;
      key_state               <= RMIS_KEY_IDLE;
    end
    else
    begin
      cts_input_selector      <= next_cts_input_selector;
      rx_input_selector       <= next_rx_input_selector;
      port_direction_register <= next_port_direction_register;
      tx_output_selector      <= next_tx_output_selector;
      map_locked              <= next_map_locked;
      key_state               <= next_key_state;
    end
  end

  // ----------------------------------------
  // read data and acknowledge
  // ----------------------------------------
  // reads only look, so they never disturb key arming
  always_comb
  begin
    next_ack     = req;
    next_rd_data = 32'h0000_0000;
    if (rd)
    begin
      case (ofs)
        RMIS_OFS_UART_IN:
          next_rd_data = {19'h0, cts_input_selector, 3'h0, rx_input_selector};
        RMIS_OFS_DIR:
          next_rd_data = {6'h00, port_direction_register};
        RMIS_OFS_OUT_MAP:
          next_rd_data = {27'h0, tx_output_selector};
        RMIS_OFS_LOCK:
          next_rd_data = {30'h0, key_state == RMIS_KEY_ARMED, map_locked};
        RMIS_OFS_KEY:
          next_rd_data = 32'h0000_0000;
        RMIS_OFS_PINS:
          next_rd_data = {6'h00, remappable_pin_n_i};
        default:
          next_rd_data = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack     <= 1'b0;
      rd_data <= 32'h0000_0000;
    end
    else
    begin
      ack     <= next_ack;
      rd_data <= next_rd_data;
    end
  end

  assign ack_o        = ack;
  assign dat_o        = rd_data;
  assign map_locked_o = map_locked;

  // ----------------------------------------
  // output mapping
  // ----------------------------------------
  // independent of the input selectors, so tx and rx may sit anywhere
  always_comb
  begin
    next_pin_out = 26'h0000000;
    next_pin_oe  = ~port_direction_register;
    if (tx_output_selector <= RMIS_SEL_MAX)
      next_pin_out[tx_output_selector] = uart_transmit_out_i;
  end

  // drivers stay off through reset so every pin floats as an input
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_out <= 26'h0000000;
      pin_oe  <= 26'h0000000;
    end
    else
    begin
      pin_out <= next_pin_out;
      pin_oe  <= next_pin_oe;
    end
  end

  assign remappable_pin_n_o    = pin_out;
  assign remappable_pin_n_oe_o = pin_oe;

  // ----------------------------------------
  // input mapping
  // ----------------------------------------
  // each mux adds one flop: a pin reaches its peripheral one cycle later
  rmis_sel_if cts_path ();
  rmis_sel_if rx_path ();

  assign cts_path.pins = remappable_pin_n_i;
  assign cts_path.dir  = port_direction_register;
  assign cts_path.sel  = cts_input_selector;
  assign rx_path.pins  = remappable_pin_n_i;
  assign rx_path.dir   = port_direction_register;
  assign rx_path.sel   = rx_input_selector;

  rmis_input_mux u_cts_mux (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .path  (cts_path)
  );

  rmis_input_mux u_rx_mux (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .path  (rx_path)
  );

  assign uart_clear_to_send_in_o = cts_path.routed;
  assign uart_receive_in_o       = rx_path.routed;
endmodule // rmis_top
`default_nettype wire
